// ===== sar_adc_analog_model.sv
// Analog front end model: twelve input levels and the comparator.
// Assumes trialCode and channelEnable are registers on core_clk.
`timescale 1ns/10ps
module sar_adc_analog_model (
  input wire logic [11:0] channelEnable,
  input wire logic [9:0] trialCode,
  input wire logic [9:0] baseLevel,
  output logic compareHigh
);
  logic [9:0] level;
  always_comb begin
    level = 10'h0;
    for (int i = 0; i < 12; i++) begin
      if (channelEnable[i]) begin
        level = baseLevel + 10'(i) * 10'h25;
      end
    end
    // No input selected: the ladder sees nothing, so every trial loses
    compareHigh = (|channelEnable) && (level >= trialCode);
  end
endmodule // sar_adc_analog_model

// ===== sar_adc_control.sv
// Top of the converter control: APB registers, start flag, channel select.
// Assumes an APB master on core_clk and an analog comparator on compareHigh.
`timescale 1ns/10ps
`include "sar_adc_control_map.svh"
module sar_adc_control import sar_adc_control_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic externalTriggerPin,
  input wire logic triggerEdgeSelect,
  input wire logic compareHigh,
  output logic [9:0] trialCode,
  output logic [11:0] channelEnable,
  output logic converterActive,
  output logic conversionEndRequest,
  output logic conversionEndIrq
);
  logic [7:0] mode_q, mode_d;
  logic startFlag_q, startFlag_d;
  logic [7:0] clockStop_q, clockStop_d;
  logic endReq_q, endReq_d;
  logic endEn_q, endEn_d;
  logic [7:0] resultHigh_q, resultHigh_d;
  logic [1:0] resultLow_q, resultLow_d;
  logic [11:0] chan_q, chan_d;
  logic [31:0] rdata_q, rdata_d;
  logic writeAcc, readAcc, mapped, standby, edgeSeen;
  logic seqStart, seqAbort, seqBusy, seqDone;
  logic [9:0] finalCode;

  function automatic logic [11:0] decodeChannel(input logic [3:0] sel);
    decodeChannel = 12'h000;
    if (sel[3:2] != 2'b00) begin
      decodeChannel[{sel[3:2] - 2'b01, sel[1:0]}] = 1'b1;
    end
  endfunction

  sar_adc_trigger_sync u_trig (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .externalTriggerPin(externalTriggerPin),
    .triggerEdgeSelect(triggerEdgeSelect),
    .edgeSeen(edgeSeen)
  );

  sar_adc_sequencer u_seq (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(seqStart),
    .abort(seqAbort),
    .hold(standby),
    .fastMode(mode_q[`MODE_SPEED_BIT]),
    .compareHigh(compareHigh),
    .busy(seqBusy),
    .done(seqDone),
    .trialCode(trialCode),
    .finalCode(finalCode)
  );

  assign pready = 1'b1;
  assign writeAcc = psel & penable & pwrite;
  assign readAcc = psel & ~penable & ~pwrite;
  assign standby = ~clockStop_q[`STANDBY_BIT];
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    if (paddr == `RESULT_HIGH_OFS) mapped = 1'b1;
    else if (paddr == `RESULT_LOW_OFS) mapped = 1'b1;
    else if (paddr == `CONVERSION_MODE_OFS) mapped = 1'b1;
    else if (paddr == `CONVERSION_START_OFS) mapped = 1'b1;
    else if (paddr == `MODULE_CLOCK_STOP_ONE_OFS) mapped = 1'b1;
    else if (paddr == `CONVERSION_END_OFS) mapped = 1'b1;
    else mapped = 1'b0;
  end

  always_comb begin
    mode_d = mode_q;
    startFlag_d = startFlag_q;
    clockStop_d = clockStop_q;
    endReq_d = endReq_q;
    endEn_d = endEn_q;
    resultHigh_d = resultHigh_q;
    resultLow_d = resultLow_q;
    seqStart = 1'b0;
    seqAbort = 1'b0;
    // Clock stop register stays writable so software can leave standby
    if (writeAcc && pstrb[0] && paddr == `MODULE_CLOCK_STOP_ONE_OFS) begin
      clockStop_d = pwdata[7:0];
    end
    if (!standby) begin
      if (writeAcc && pstrb[0]) begin
        if (paddr == `CONVERSION_MODE_OFS) begin
          mode_d = {pwdata[7:6], 2'b11, pwdata[3:0]};
        end else if (paddr == `CONVERSION_START_OFS) begin
          if (pwdata[`START_FLAG_BIT]) begin
            startFlag_d = 1'b1;
            seqStart = ~seqBusy;
          end else begin
            startFlag_d = 1'b0;
            seqAbort = 1'b1;
          end
        end else if (paddr == `CONVERSION_END_OFS) begin
          endEn_d = pwdata[`END_EN_BIT];
          if (!pwdata[`END_REQ_BIT]) begin
            endReq_d = 1'b0;
          end
        end
      end
      if (mode_q[`MODE_TRIG_BIT] && edgeSeen && !startFlag_q) begin
        startFlag_d = 1'b1;
        seqStart = 1'b1;
      end
      if (seqDone && startFlag_q) begin
        resultHigh_d = finalCode[9:2];
        resultLow_d = finalCode[1:0];
        startFlag_d = 1'b0;
        endReq_d = 1'b1;
      end
    end
  end

  always_comb begin
    chan_d = decodeChannel(mode_q[3:0]);
    rdata_d = rdata_q;
    if (readAcc) begin
      if (paddr == `RESULT_HIGH_OFS) rdata_d = {24'h000000, resultHigh_q};
      else if (paddr == `RESULT_LOW_OFS) rdata_d = {24'h000000, resultLow_q, 6'h00};
      else if (paddr == `CONVERSION_MODE_OFS) rdata_d = {24'h000000, mode_q | `MODE_FIXED_ONES};
      else if (paddr == `CONVERSION_START_OFS)
        rdata_d = {24'h000000, startFlag_q, 7'h7f};
      else if (paddr == `MODULE_CLOCK_STOP_ONE_OFS) rdata_d = {24'h000000, clockStop_q};
      else if (paddr == `CONVERSION_END_OFS)
        rdata_d = {30'h00000000, endEn_q, endReq_q};
      else rdata_d = 32'h00000000;
    end
  end

  assign prdata = rdata_q;
  assign converterActive = startFlag_q & ~standby;
  assign conversionEndRequest = endReq_q;
  assign conversionEndIrq = endReq_q & endEn_q;

  // Result flops carry no reset so their content survives a reset
  always_ff @(posedge core_clk) begin
    resultHigh_q <= resultHigh_d;
    resultLow_q <= resultLow_d;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `MODE_RESET;
      startFlag_q <= 1'b0;
      clockStop_q <= `CLOCK_STOP_RESET;
      endReq_q <= 1'b0;
      endEn_q <= 1'b0;
      chan_q <= 12'h000;
      rdata_q <= 32'h00000000;
    end else begin
      mode_q <= mode_d;
      startFlag_q <= startFlag_d;
      clockStop_q <= clockStop_d;
      endReq_q <= endReq_d;
      endEn_q <= endEn_d;
      chan_q <= chan_d;
      rdata_q <= rdata_d;
    end
  end

  assign channelEnable = chan_q;
endmodule // sar_adc_control

// ===== sar_adc_control_map.svh
// Register offsets, field positions, reset values and timing counts.
// Included by the converter control modules; definitions only.
`ifndef SAR_ADC_CONTROL_MAP_SVH
`define SAR_ADC_CONTROL_MAP_SVH

`define RESULT_HIGH_OFS 16'hffc4
`define RESULT_LOW_OFS 16'hffc5
`define CONVERSION_MODE_OFS 16'hffc6
`define CONVERSION_START_OFS 16'hffc7
`define MODULE_CLOCK_STOP_ONE_OFS 16'hfffa
`define CONVERSION_END_OFS 16'hfffc

`define MODE_SPEED_BIT 7
`define MODE_TRIG_BIT 6
`define START_FLAG_BIT 7
`define STANDBY_BIT 4
`define END_REQ_BIT 0
`define END_EN_BIT 1

`define MODE_RESET 8'h30
`define MODE_FIXED_ONES 8'h30
`define START_FIXED_ONES 8'h7f
`define CLOCK_STOP_RESET 8'hff

`define SLOW_PERIOD 7'd62
`define FAST_PERIOD 7'd31
`define RESULT_BITS 10

`endif

// ===== sar_adc_control_pkg.sv
// Types shared by the converter control modules.
// Assumes the map header supplies all numeric constants.
package sar_adc_control_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RUN,
    SEQ_DONE
  } seq_state_t;
  typedef logic [9:0] result_t;
endpackage

// ===== sar_adc_control_sva.sv
// Port checker for the converter control.
// Bound to every sar_adc_control instance; sees its ports only.
`timescale 1ns/10ps
`include "sar_adc_control_map.svh"
module sar_adc_control_sva (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic externalTriggerPin,
  input wire logic triggerEdgeSelect,
  input wire logic compareHigh,
  input wire logic [9:0] trialCode,
  input wire logic [11:0] channelEnable,
  input wire logic converterActive,
  input wire logic conversionEndRequest,
  input wire logic conversionEndIrq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire rdAcc = psel && penable && !pwrite;
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("access phase without ready");
  property p_startOnes; rdAcc && paddr == `CONVERSION_START_OFS |-> prdata[6:0] == 7'h7f; endproperty
  a_startOnes: assert property (p_startOnes)
    else $error("start register low bits not all one");
  property p_modeOnes; rdAcc && paddr == `CONVERSION_MODE_OFS |-> prdata[5:4] == 2'h3; endproperty
  a_modeOnes: assert property (p_modeOnes)
    else $error("mode register bits 5 and 4 not one");
  property p_chan; $onehot0(channelEnable); endproperty
  a_chan: assert property (p_chan)
    else $error("more than one input selected");
  property p_endFlag; $rose(conversionEndRequest) |-> $fell(converterActive); endproperty
  a_endFlag: assert property (p_endFlag)
    else $error("end flag set without flag clearing");
  property p_irq; conversionEndIrq |-> conversionEndRequest; endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt without end request");
  // Standby or abort also ends activity; the bound fails if a trigger edge meets an abort write, leaving the start flag set with the sequencer idle
  property p_bound; $rose(converterActive) |-> ##[1:70] !converterActive; endproperty
  a_bound: assert property (p_bound)
    else $error("conversion ran too long");
  property p_idleHold; !converterActive [*4] |-> $stable(trialCode); endproperty
  a_idleHold: assert property (p_idleHold)
    else $error("trial word moved while idle");
endmodule // sar_adc_control_sva
bind sar_adc_control sar_adc_control_sva chk (.*);

// ===== sar_adc_control_tb.sv
// Bench for the converter control: registers, conversions, trigger, standby.
// Assumes the analog model answers within the cycle of each trial.
`timescale 1ns/10ps
`include "sar_adc_control_map.svh"
module sar_adc_control_tb import sar_adc_control_pkg::*;;
  localparam logic [15:0] aMode = `CONVERSION_MODE_OFS;
  localparam logic [15:0] aStart = `CONVERSION_START_OFS;
  localparam logic [15:0] aStop = `MODULE_CLOCK_STOP_ONE_OFS;
  localparam logic [15:0] aEnd = `CONVERSION_END_OFS;
  logic core_clk, arst_n, psel, penable, pwrite, pready, pslverr, e, compareHigh;
  logic externalTriggerPin, triggerEdgeSelect, converterActive;
  logic conversionEndRequest, conversionEndIrq;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [9:0] trialCode, baseLevel;
  logic [11:0] channelEnable;
  logic [7:0] q, h, l;
  int errors, cmp_count, n, cycles = 0;
  time t0;
  sar_adc_control dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .externalTriggerPin(externalTriggerPin),
    .triggerEdgeSelect(triggerEdgeSelect), .compareHigh(compareHigh), .trialCode(trialCode),
    .channelEnable(channelEnable), .converterActive(converterActive),
    .conversionEndRequest(conversionEndRequest), .conversionEndIrq(conversionEndIrq));
  sar_adc_analog_model ana (.channelEnable(channelEnable), .trialCode(trialCode),
    .baseLevel(baseLevel), .compareHigh(compareHigh));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  task wrap_up;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A hang anywhere counts against the run
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      wrap_up;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task waitEnd;
    n = 0;
    while (conversionEndRequest !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
  endtask
  function logic [11:0] sel(input logic [3:0] c);
    return (c[3:2] == 2'h0) ? 12'h0 : 12'h1 << ((c[3:2] - 1) * 4 + c[1:0]);
  endfunction
  function result_t lvl(input logic [3:0] c, input logic [9:0] b);
    return b + 10'((c[3:2] - 1) * 4 + c[1:0]) * 10'h25;
  endfunction
  task conv(input logic [3:0] c, input logic f);
    baseLevel <= 10'($urandom);
    apb(1'b1, aMode, {f, 3'h0, c});
    apb(1'b0, aMode, 8'h0);
    chk(q, {f, 3'h3, c});
    chk(channelEnable, sel(c));
    apb(1'b1, aEnd, 8'h02);
    apb(1'b1, aStart, 8'h80);
    t0 = $time;
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'hff);
    waitEnd;
    n = ($time - t0) / 8;
    chk(n >= (f ? 30 : 61) && n <= (f ? 37 : 68), 1);
    chk(conversionEndIrq, 1'b1);
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'h7f);
    apb(1'b0, `RESULT_HIGH_OFS, 8'h0);
    h = q;
    apb(1'b0, `RESULT_LOW_OFS, 8'h0);
    chk({h, q[7:6]}, lvl(c, baseLevel));
    apb(1'b0, `RESULT_HIGH_OFS, 8'h0);
    chk(q, h);
  endtask
  initial begin
    {arst_n, psel, penable, pwrite, externalTriggerPin} = 5'h0;
    {paddr, pwdata, baseLevel} = 58'h0;
    pstrb = 4'h1;
    triggerEdgeSelect = 1'b1;
    errors = 0;
    cmp_count = 0;
    void'($urandom(52386));
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, aMode, 8'h0);
    chk(q, 8'h30);
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'h7f);
    apb(1'b0, aStop, 8'h0);
    chk(q, 8'hff);
    apb(1'b0, 16'hffd0, 8'h0);
    chk({e, q}, 9'h100);
    for (int i = 0; i < 16; i++) begin
      if (i < 4) begin
        // Select some input first so that a missing clear would show
        apb(1'b1, aMode, 8'h09);
        apb(1'b1, aMode, 8'(i));
        repeat (2) @(posedge core_clk);
        chk(channelEnable, 12'h0);
      end else conv(4'(i), 1'(i));
    end
    repeat (3) conv(4'(4 + $urandom % 12), 1'($urandom));
    apb(1'b1, aEnd, 8'h02);
    apb(1'b1, aStart, 8'h80);
    repeat (5) @(posedge core_clk);
    apb(1'b1, aStart, 8'h00);
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'h7f);
    repeat (80) @(posedge core_clk);
    chk(conversionEndRequest, 1'b0);
    apb(1'b1, aMode, 8'h05);
    externalTriggerPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    externalTriggerPin <= 1'b0;
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'h7f);
    apb(1'b1, aMode, 8'h45);
    externalTriggerPin <= 1'b1;
    repeat (6) @(posedge core_clk);
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'hff);
    waitEnd;
    apb(1'b1, aEnd, 8'h00);
    triggerEdgeSelect <= 1'b0;
    repeat (4) @(posedge core_clk);
    externalTriggerPin <= 1'b0;
    repeat (6) @(posedge core_clk);
    apb(1'b0, aStart, 8'h0);
    chk(q, 8'hff);
    waitEnd;
    chk({conversionEndRequest, conversionEndIrq}, 2'h2);
    apb(1'b1, aMode, 8'h06);
    apb(1'b1, aEnd, 8'h02);
    apb(1'b1, aStart, 8'h80);
    apb(1'b1, aStop, 8'hef);
    apb(1'b0, aStop, 8'h0);
    chk(q, 8'hef);
    apb(1'b1, aMode, 8'h8b);
    repeat (100) @(posedge core_clk);
    chk({conversionEndRequest, converterActive}, 2'h0);
    apb(1'b1, aStop, 8'hff);
    apb(1'b0, aMode, 8'h0);
    chk(q, 8'h36);
    waitEnd;
    chk(conversionEndRequest, 1'b1);
    repeat (10) @(posedge core_clk);
    conv(4'h9, 1'b0);
    apb(1'b0, `RESULT_LOW_OFS, 8'h0);
    l = q;
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    apb(1'b0, `RESULT_HIGH_OFS, 8'h0);
    chk(q, h);
    apb(1'b0, `RESULT_LOW_OFS, 8'h0);
    chk(q[7:6], l[7:6]);
    wrap_up;
  end
endmodule // sar_adc_control_tb

// ===== sar_adc_sequencer.sv
// Conversion sequencer: period counter and successive approximation register.
// Assumes the comparator output is synchronous to core_clk.
`timescale 1ns/10ps
`include "sar_adc_control_map.svh"
module sar_adc_sequencer import sar_adc_control_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic abort,
  input wire logic hold,
  input wire logic fastMode,
  input wire logic compareHigh,
  output logic busy,
  output logic done,
  output logic [9:0] trialCode,
  output logic [9:0] finalCode
);
  seq_state_t state_q, state_d;
  logic [6:0] count_q, count_d;
  logic [9:0] sar_q, sar_d;
  logic [3:0] bit_q, bit_d;
  logic [6:0] stepLen;

  function automatic logic [6:0] periodOf(input logic fast);
    periodOf = fast ? `FAST_PERIOD : `SLOW_PERIOD;
  endfunction

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    sar_d = sar_q;
    bit_d = bit_q;
    done = 1'b0;
    // Spread ten trials over the period; a step ends every period/10 clocks
    stepLen = periodOf(fastMode) / 7'd10;
    if (hold) begin
      state_d = state_q;
    end else if (abort) begin
      state_d = SEQ_IDLE;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (start) begin
            state_d = SEQ_RUN;
            count_d = periodOf(fastMode) - 7'd1;
            sar_d = 10'h200;
            bit_d = 4'd9;
          end
        end
        SEQ_RUN: begin
          count_d = count_q - 7'd1;
          if ((count_q % stepLen) == 7'd0 && bit_q != 4'hf) begin
            sar_d[bit_q] = compareHigh;
            if (bit_q != 4'd0) begin
              sar_d[bit_q - 4'd1] = 1'b1;
            end
            bit_d = bit_q - 4'd1;
          end
          if (count_q == 7'd0) begin
            state_d = SEQ_DONE;
          end
        end
        SEQ_DONE: begin
          done = 1'b1;
          state_d = SEQ_IDLE;
        end
        default: state_d = SEQ_IDLE;
      endcase
    end
  end

  assign busy = (state_q != SEQ_IDLE);
  assign trialCode = sar_q;
  assign finalCode = sar_q;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SEQ_IDLE;
      count_q <= 7'd0;
      sar_q <= 10'h000;
      bit_q <= 4'd0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      sar_q <= sar_d;
      bit_q <= bit_d;
    end
  end
endmodule // sar_adc_sequencer

// ===== sar_adc_trigger_sync.sv
// External trigger synchroniser and edge detector.
// Assumes the trigger pin is asynchronous to core_clk.
`timescale 1ns/10ps
`include "sar_adc_control_map.svh"
module sar_adc_trigger_sync import sar_adc_control_pkg::*; (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic externalTriggerPin,
  input wire logic triggerEdgeSelect,
  output logic edgeSeen
);
  logic meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;

  always_comb begin
    meta_d = externalTriggerPin;
    sync_d = meta_q;
    prev_d = sync_q;
    // Edge select high means rising edge
    edgeSeen = triggerEdgeSelect ? (sync_q & ~prev_q) : (~sync_q & prev_q);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end
endmodule // sar_adc_trigger_sync
